// File: rtl/hps_status_regs.sv
// Status and interrupt register bank of a dual-slot hot plug controller
//
// Function
// - Slot A status reads at command 04, slot B at command 05.
// - Slot status registers reset to 00; slots start with outputs off.
// - Writing 1 to a set overcurrent flag clears it and releases interrupt.
// - Reading a slot status register leaves the fault pin unchanged.
// - Slot status: fault, main state, aux state, five overcurrent flags.
// - Fault bit reads 1 while fault pin low, 0 while high.
// - Main overcurrent fault stays latched until main-on input goes low.
// - Aux overcurrent fault stays latched until aux enable input goes low.
// - Main and aux faults together clear only when both inputs low.
// - Fault bit and pin stay inactive under management bus control.
// - Common status at command 06, resets 00, mirrors general inputs.
// - Mask bit 3 at 0 enables interrupt, at 1 disables it.
// - Undervoltage flag bit 2 sets on lockout breaker trip.
// - Undervoltage flag sets only while some slot main is requested.
// - Overtemperature flag bit 1 sets on thermal breaker trip.
// - Undervoltage and overtemperature flags clear only by writing 1.
`timescale 1ns/1ps
module hps_status_regs (
   input  wire logic       clk,
   input  wire logic       rstn,
   // Command port from the bus protocol engine
   input  wire logic       cmd_valid,
   input  wire logic       cmd_write,
   input  wire logic [7:0] cmd_byte,
   input  wire logic [7:0] cmd_wdata,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   // Slot pins
   input  wire logic       slot_a_main_on_pin,
   input  wire logic       slot_b_main_on_pin,
   input  wire logic       slot_a_aux_enable_input,
   input  wire logic       slot_b_aux_enable_input,
   input  wire logic       slot_a_general_input,
   input  wire logic       slot_b_general_input,
   // Analog side: actual output states and protection events
   input  wire logic       slot_a_main_on_state,
   input  wire logic       slot_b_main_on_state,
   input  wire logic       slot_a_aux_on_state,
   input  wire logic       slot_b_aux_on_state,
   input  wire logic [4:0] slot_a_overcurrent,
   input  wire logic [4:0] slot_b_overcurrent,
   input  wire logic       undervoltage_lockout,
   input  wire logic       overtemperature_trip,
   // Same-domain bits from the slot control registers
   input  wire logic       slot_a_main_enable_bit,
   input  wire logic       slot_b_main_enable_bit,
   input  wire logic       slot_a_management_bus_control,
   input  wire logic       slot_b_management_bus_control,
   // Outputs
   output logic            slot_a_fault_pin_n,
   output logic            slot_b_fault_pin_n,
   output logic            int_n
);

   localparam int W = hps_pkg::OC_W;

   // Clear-by-one with set winning over a clear in the same cycle
   function automatic logic [4:0] hps_w1c(input logic [4:0] cur,
                                          input logic [4:0] set,
                                          input logic [4:0] clr);
      return (cur & ~clr) | set;
   endfunction

   // Asynchronous pin and analog inputs, gathered for synchronising
   localparam int SW = 2 * W + 12;
   logic [SW-1:0] raw;
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;

   assign raw = {slot_b_overcurrent, slot_a_overcurrent,
                 undervoltage_lockout, overtemperature_trip,
                 slot_b_main_on_pin, slot_a_main_on_pin,
                 slot_b_aux_enable_input, slot_a_aux_enable_input,
                 slot_b_general_input, slot_a_general_input,
                 slot_b_main_on_state, slot_a_main_on_state,
                 slot_b_aux_on_state, slot_a_aux_on_state};

   // Two flops before any logic looks at a pin
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   logic [W-1:0] oc_b_s;
   logic [W-1:0] oc_a_s;
   logic         uv_s;
   logic         ot_s;
   logic [1:0]   main_on_s;
   logic [1:0]   aux_en_s;
   logic [1:0]   gpi_s;
   logic [1:0]   main_st_s;
   logic [1:0]   aux_st_s;

   assign {oc_b_s, oc_a_s, uv_s, ot_s, main_on_s, aux_en_s,
           gpi_s, main_st_s, aux_st_s} = sync2;

   // Event detection: protection inputs may stay high after a trip,
   // so flags are set on the rising edge only; a held level would
   // otherwise defeat every clear-by-one write.
   logic [W-1:0] oc_a_prev;
   logic [W-1:0] oc_b_prev;
   logic         uv_prev;
   logic         ot_prev;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oc_a_prev <= '0;
         oc_b_prev <= '0;
         uv_prev   <= 1'b0;
         ot_prev   <= 1'b0;
      end else begin
         oc_a_prev <= oc_a_s;
         oc_b_prev <= oc_b_s;
         uv_prev   <= uv_s;
         ot_prev   <= ot_s;
      end
   end

   logic [W-1:0] oc_a_rise;
   logic [W-1:0] oc_b_rise;
   logic         uv_rise;
   logic         ot_rise;

   assign oc_a_rise = oc_a_s & ~oc_a_prev;
   assign oc_b_rise = oc_b_s & ~oc_b_prev;
   assign uv_rise   = uv_s & ~uv_prev;
   assign ot_rise   = ot_s & ~ot_prev;

   // Command decode
   logic wr;
   logic rd;
   logic wr_a;
   logic wr_b;
   logic wr_c;

   assign wr   = cmd_valid & cmd_write;
   assign rd   = cmd_valid & ~cmd_write;
   assign wr_a = wr & (cmd_byte == hps_pkg::CMD_SLOT_A);
   assign wr_b = wr & (cmd_byte == hps_pkg::CMD_SLOT_B);
   assign wr_c = wr & (cmd_byte == hps_pkg::CMD_COMMON);

   // Overcurrent flags per slot
   logic [W-1:0] oc_a_flag;
   logic [W-1:0] oc_b_flag;
   logic [W-1:0] next_oc_a;
   logic [W-1:0] next_oc_b;

   assign next_oc_a = hps_w1c(oc_a_flag, oc_a_rise,
                              wr_a ? cmd_wdata[W-1:0] : '0);
   assign next_oc_b = hps_w1c(oc_b_flag, oc_b_rise,
                              wr_b ? cmd_wdata[W-1:0] : '0);

   // Common flags and mask
   logic uv_flag;
   logic ot_flag;
   logic int_mask;
   logic main_req;
   logic next_uv;
   logic next_ot;

   // Either slot asked for main power, by pin or by control bit
   assign main_req = (|main_on_s) | slot_a_main_enable_bit
                     | slot_b_main_enable_bit;
   assign next_uv  = (uv_flag & ~(wr_c & cmd_wdata[hps_pkg::UV_BIT]))
                     | (uv_rise & main_req);
   assign next_ot  = (ot_flag & ~(wr_c & cmd_wdata[hps_pkg::OT_BIT]))
                     | ot_rise;

   // Flags only move by hardware set or clear-by-one write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oc_a_flag <= '0;
         oc_b_flag <= '0;
         uv_flag   <= 1'b0;
         ot_flag   <= 1'b0;
         int_mask  <= 1'b0;
      end else begin
         oc_a_flag <= next_oc_a;
         oc_b_flag <= next_oc_b;
         uv_flag   <= next_uv;
         ot_flag   <= next_ot;
         if (wr_c) begin
            int_mask <= cmd_wdata[hps_pkg::MASK_BIT];
         end
      end
   end

   // Fault latches: main faults wait for main-on low, aux faults for
   // aux enable low; with both latched the pin holds until both clear.
   logic [1:0] mgmt;
   logic [1:0] main_lat;
   logic [1:0] aux_lat;
   logic [1:0] fault_act;
   logic [1:0] main_oc_ev;
   logic [1:0] aux_oc_ev;
   logic [1:0] next_main_lat;
   logic [1:0] next_aux_lat;
   logic [1:0] next_fault;

   assign mgmt       = {slot_b_management_bus_control,
                        slot_a_management_bus_control};
   assign main_oc_ev = {|(oc_b_rise & hps_pkg::MAIN_OC),
                        |(oc_a_rise & hps_pkg::MAIN_OC)};
   assign aux_oc_ev  = {oc_b_rise[hps_pkg::AUX_OC],
                        oc_a_rise[hps_pkg::AUX_OC]};
   // Under bus control the latches are held clear, so the fault pins stay high
   assign next_main_lat = ((main_lat & main_on_s) | main_oc_ev) & ~mgmt;
   assign next_aux_lat  = ((aux_lat & aux_en_s) | aux_oc_ev) & ~mgmt;
   assign next_fault    = next_main_lat | next_aux_lat;

   // Fault bit and pin come from the same next value, so they agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         main_lat           <= '0;
         aux_lat            <= '0;
         fault_act          <= '0;
         slot_a_fault_pin_n <= 1'b1;
         slot_b_fault_pin_n <= 1'b1;
      end else begin
         main_lat           <= next_main_lat;
         aux_lat            <= next_aux_lat;
         fault_act          <= next_fault;
         slot_a_fault_pin_n <= ~next_fault[0];
         slot_b_fault_pin_n <= ~next_fault[1];
      end
   end

   // Register images
   logic [7:0] stat_a;
   logic [7:0] stat_b;
   logic [7:0] stat_c;
   logic [7:0] rd_mux;

   assign stat_a = {fault_act[0], main_st_s[0], aux_st_s[0], oc_a_flag};
   assign stat_b = {fault_act[1], main_st_s[1], aux_st_s[1], oc_b_flag};
   assign stat_c = {hps_pkg::RSVD_HI, gpi_s[1], gpi_s[0], int_mask,
                    uv_flag, ot_flag, hps_pkg::RSVD_LO};
   // Reads have no side effect on flags or pins
   assign rd_mux = (cmd_byte == hps_pkg::CMD_SLOT_A) ? stat_a :
                   (cmd_byte == hps_pkg::CMD_SLOT_B) ? stat_b :
                   (cmd_byte == hps_pkg::CMD_COMMON) ? stat_c :
                   hps_pkg::RST_VAL;

   // Interrupt from registered flags; one cycle behind the flag
   logic any_flag;

   assign any_flag = (|oc_a_flag) | (|oc_b_flag) | uv_flag | ot_flag;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data  <= hps_pkg::RST_VAL;
         rd_valid <= 1'b0;
         int_n    <= 1'b1;
      end else begin
         rd_valid <= rd;
         if (rd) begin
            rd_data <= rd_mux;
         end
         int_n <= ~(any_flag & ~int_mask);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_rd_a;
      rd && cmd_byte == hps_pkg::CMD_SLOT_A |=> rd_valid && rd_data == $past(stat_a);
   endproperty
   a_rd_a: assert property (p_rd_a) else $error("slot A read wrong");

   property p_rd_c;
      rd && cmd_byte == hps_pkg::CMD_COMMON |=>
         rd_data[7:6] == hps_pkg::RSVD_HI && rd_data[5:4] == $past(gpi_s);
   endproperty
   a_rd_c: assert property (p_rd_c) else $error("common reserved set");

   property p_w1c;
      wr_a && cmd_wdata[0] && !oc_a_rise[0] |=> !oc_a_flag[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");

   localparam int AUX_OC_I = hps_pkg::AUX_OC;
   property p_oc_set;
      oc_b_rise[AUX_OC_I] && !mgmt[1] |=> oc_b_flag[AUX_OC_I] && !slot_b_fault_pin_n;
   endproperty
   a_oc_set: assert property (p_oc_set) else $error("oc flag lost");

   property p_pin;
      fault_act[0] == !slot_a_fault_pin_n;
   endproperty
   a_pin: assert property (p_pin) else $error("fault bit and pin differ");

   property p_main_clr;
      !main_on_s[0] && !main_oc_ev[0] |=> !main_lat[0];
   endproperty
   a_main_clr: assert property (p_main_clr) else $error("main fault held");

   property p_aux_clr;
      aux_lat[1] && aux_en_s[1] && !mgmt[1] |=> aux_lat[1];
   endproperty
   a_aux_clr: assert property (p_aux_clr) else $error("aux fault lost");

   property p_mgmt;
      mgmt[0] |=> slot_a_fault_pin_n && !fault_act[0];
   endproperty
   a_mgmt: assert property (p_mgmt) else $error("fault active under bus control");

   property p_mask;
      int_mask |=> int_n;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt asserted");

   property p_uv;
      !uv_flag && !main_req |=> !uv_flag;
   endproperty
   a_uv: assert property (p_uv) else $error("uv flag without request");

   property p_ot;
      ot_flag && !(wr_c && cmd_wdata[hps_pkg::OT_BIT]) |=> ot_flag;
   endproperty
   a_ot: assert property (p_ot) else $error("ot flag dropped");

   property p_int;
      any_flag && !int_mask |=> !int_n;
   endproperty
   a_int: assert property (p_int) else $error("interrupt not asserted");

endmodule // hps_status_regs

// File: include/hps_pkg.sv
// Shared constants for the hot plug status register bank
package hps_pkg;
   // Command bytes that select the status registers
   localparam logic [7:0] CMD_SLOT_A = 8'h04;
   localparam logic [7:0] CMD_SLOT_B = 8'h05;
   localparam logic [7:0] CMD_COMMON = 8'h06;
   // Power-up value of every register and of unmapped reads
   localparam logic [7:0] RST_VAL    = 8'h00;
   // Number of overcurrent flags per slot
   localparam int         OC_W       = 5;
   // Flags 3..0 belong to the main outputs, flag 4 to the aux output
   localparam logic [4:0] MAIN_OC    = 5'h0F;
   localparam int         AUX_OC     = 4;
   // Common status field positions
   localparam int         MASK_BIT   = 3;
   localparam int         UV_BIT     = 2;
   localparam int         OT_BIT     = 1;
   // Reserved high bits of the common register read as zero
   localparam logic [1:0] RSVD_HI    = 2'h0;
   localparam logic       RSVD_LO    = 1'h0;
endpackage

// File: verif/hps_host_model.sv
// Management bus host model that drives the register command port
`timescale 1ns/1ps
module hps_host_model (
   input  wire logic       clk,
   output logic            cmd_valid,
   output logic            cmd_write,
   output logic [7:0]      cmd_byte,
   output logic [7:0]      cmd_wdata,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   // Idle values differ from any real request
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_byte  = 8'hA5;
      cmd_wdata = 8'h5A;
   end

   // One request per call; released qualifiers are scrambled so no stale value lingers
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
                       output logic [7:0] rd, output logic ok);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_byte  <= cmd;
      cmd_wdata <= wd;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_write <= ~wr;
      cmd_byte  <= ~cmd;
      cmd_wdata <= ~wd;
      #1;
      ok = (rd_valid === ~wr);
      rd = rd_data;
   endtask
endmodule // hps_host_model

// File: verif/hps_status_regs_tb_top.sv
// Self-checking bench for the hot plug status register bank
`timescale 1ns/1ps
module hps_status_regs_tb_top;
   logic       clk = 1'b0, rstn = 1'b0;
   logic       cmd_valid, cmd_write, rd_valid, a_flt_n, b_flt_n, int_n;
   logic [7:0] cmd_byte, cmd_wdata, rd_data;
   logic       a_on = 1'b0, b_on = 1'b0, a_aux = 1'b0, b_aux = 1'b0, a_gp = 1'b0, b_gp = 1'b0;
   logic       a_ms = 1'b0, b_ms = 1'b0, a_as = 1'b0, b_as = 1'b0, uvlo = 1'b0, otrip = 1'b0;
   logic       a_men = 1'b0, b_men = 1'b0, a_bus = 1'b0, b_bus = 1'b0;
   logic [4:0] a_oc = 5'h00, b_oc = 5'h00;
   int         miscompares = 0, n_tests = 0;

   hps_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

   hps_status_regs dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .slot_a_main_on_pin(a_on), .slot_b_main_on_pin(b_on),
      .slot_a_aux_enable_input(a_aux), .slot_b_aux_enable_input(b_aux),
      .slot_a_general_input(a_gp), .slot_b_general_input(b_gp),
      .slot_a_main_on_state(a_ms), .slot_b_main_on_state(b_ms),
      .slot_a_aux_on_state(a_as), .slot_b_aux_on_state(b_as),
      .slot_a_overcurrent(a_oc), .slot_b_overcurrent(b_oc),
      .undervoltage_lockout(uvlo), .overtemperature_trip(otrip),
      .slot_a_main_enable_bit(a_men), .slot_b_main_enable_bit(b_men),
      .slot_a_management_bus_control(a_bus), .slot_b_management_bus_control(b_bus),
      .slot_a_fault_pin_n(a_flt_n), .slot_b_fault_pin_n(b_flt_n), .int_n(int_n));

   // Free-running 125 MHz clock
   initial begin
      forever #4 clk = ~clk;
   end

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask

   // Pin events pass a two-stage synchroniser, so waits leave margin past three edges
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host.xfer(1'b0, cmd, 8'h00, d, ok);
      chk_bit(ok, 1'b1);
      chk_byte(d, exp);
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [7:0] wd);
      logic [7:0] d;
      logic       ok;
      host.xfer(1'b1, cmd, wd, d, ok);
      chk_bit(ok, 1'b1);
   endtask

   task automatic t_reset();
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h05, 8'h00);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h07, 8'h00);
      chk_bit(a_flt_n & b_flt_n & int_n, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_mirror();
      @(posedge clk);
      a_ms <= 1'b1;
      b_as <= 1'b1;
      a_gp <= 1'b1;
      settle(4);
      rd_chk(8'h04, 8'h40);
      rd_chk(8'h05, 8'h20);
      rd_chk(8'h06, 8'h10);
      @(posedge clk);
      a_ms <= 1'b0;
      b_as <= 1'b0;
      a_gp <= 1'b0;
      b_gp <= 1'b1;
      settle(4);
      rd_chk(8'h06, 8'h20);
      @(posedge clk);
      b_gp <= 1'b0;
      $display("test mirror done");
   endtask

   task automatic t_main_fault();
      @(posedge clk);
      a_on <= 1'b1;
      settle(3);
      @(posedge clk);
      a_oc <= 5'h02;
      settle(6);
      chk_bit(a_flt_n, 1'b0);
      chk_bit(int_n, 1'b0);
      @(posedge clk);
      a_oc <= 5'h00;
      rd_chk(8'h04, 8'h82);
      rd_chk(8'h04, 8'h82);
      chk_bit(a_flt_n, 1'b0);
      // Ones into read-only bits must be ignored
      wr(8'h04, 8'hE2);
      settle(2);
      chk_bit(int_n, 1'b1);
      rd_chk(8'h04, 8'h80);
      @(posedge clk);
      a_on <= 1'b0;
      settle(5);
      chk_bit(a_flt_n, 1'b1);
      $display("test main fault done");
   endtask

   task automatic t_aux_faults();
      @(posedge clk);
      a_aux <= 1'b1;
      b_aux <= 1'b1;
      b_on <= 1'b1;
      settle(3);
      @(posedge clk);
      a_oc <= 5'h10;
      b_oc <= 5'h14;
      settle(6);
      rd_chk(8'h05, 8'h94);
      chk_bit(a_flt_n, 1'b0);
      @(posedge clk);
      a_oc <= 5'h00;
      b_oc <= 5'h00;
      a_aux <= 1'b0;
      b_aux <= 1'b0;
      // Enable drop needs two sync edges plus one to clear the latch
      settle(4);
      chk_bit(b_flt_n, 1'b0);
      chk_bit(a_flt_n, 1'b1);
      @(posedge clk);
      b_on <= 1'b0;
      settle(5);
      chk_bit(b_flt_n, 1'b1);
      wr(8'h04, 8'h10);
      wr(8'h05, 8'h14);
      rd_chk(8'h05, 8'h00);
      settle(1);
      chk_bit(int_n, 1'b1);
      $display("test aux faults done");
   endtask

   task automatic t_bus_ctl();
      @(posedge clk);
      a_bus <= 1'b1;
      b_bus <= 1'b1;
      a_oc <= 5'h01;
      b_oc <= 5'h10;
      // With the enables low an ungated fault would only pulse, so look every cycle
      repeat (6) begin
         settle(1);
         chk_bit(a_flt_n & b_flt_n, 1'b1);
      end
      rd_chk(8'h04, 8'h01);
      rd_chk(8'h05, 8'h10);
      wr(8'h04, 8'h01);
      wr(8'h05, 8'h10);
      @(posedge clk);
      a_oc <= 5'h00;
      b_oc <= 5'h00;
      a_bus <= 1'b0;
      b_bus <= 1'b0;
      $display("test bus control done");
   endtask

   task automatic t_common();
      @(posedge clk);
      uvlo <= 1'b1;
      settle(6);
      rd_chk(8'h06, 8'h00);
      @(posedge clk);
      uvlo <= 1'b0;
      a_men <= 1'b1;
      settle(3);
      @(posedge clk);
      uvlo <= 1'b1;
      settle(6);
      rd_chk(8'h06, 8'h04);
      chk_bit(int_n, 1'b0);
      @(posedge clk);
      uvlo <= 1'b0;
      a_men <= 1'b0;
      wr(8'h06, 8'h08);
      settle(2);
      chk_bit(int_n, 1'b1);
      wr(8'h06, 8'hF9);
      rd_chk(8'h06, 8'h0C);
      @(posedge clk);
      otrip <= 1'b1;
      settle(6);
      rd_chk(8'h06, 8'h0E);
      chk_bit(int_n, 1'b1);
      @(posedge clk);
      otrip <= 1'b0;
      wr(8'h06, 8'h06);
      rd_chk(8'h06, 8'h00);
      chk_bit(int_n, 1'b1);
      $display("test common done");
   endtask

   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Main sequence: reset for six cycles, then each scenario in turn
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_mirror();
      t_main_fault();
      t_aux_faults();
      t_bus_ctl();
      t_common();
      wrap_up();
   end

   // Guard against a hang anywhere in the sequence
   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
endmodule // hps_status_regs_tb_top
